// >>> src/adv_ber_regs.vh
`ifndef ADV_BER_REGS_VH
`define ADV_BER_REGS_VH
`define LOCAL_ADV_BASE     14'h0083
`define BACK_ADV_BASE      14'h00A3
`define SEND_START_ADDR    14'h00C3
`define SEND_LEN_ADDR      14'h00C4
`define RECV_LEN_ADDR      14'h00C5
`define RECV_START_ADDR    14'h00C6
`define ERR_COUNT_ADDR     14'h00C7
`define ADV_CODE_HI        1
`define STREAM_HI          12
`define STREAM_LO          8
`define CHAN_HI            7
`define REG_RESET          16'h0000
`define ERR_COUNT_MAX      16'hFFFF
`define PRBS_SEED          15'h7FFF
`define BACK32_STREAMS     16
`endif

// >>> src/data_fifo.v
`timescale 1ns/10ps
module data_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 8,
   parameter AW    = 3
) (
   input  wire             clk,
   input  wire             rst,
   input  wire             in_valid,
   output wire             in_ready,
   input  wire [WIDTH-1:0] in_data,
   output wire             out_valid,
   input  wire             out_ready,
   output wire [WIDTH-1:0] out_data
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW:0]      wr_r;
   reg [AW:0]      rd_r;
   wire            full;
   wire            empty;
   assign full      = (wr_r[AW-1:0] == rd_r[AW-1:0]) && (wr_r[AW] != rd_r[AW]);
   assign empty     = (wr_r == rd_r);
   assign in_ready  = !full;
   assign out_valid = !empty;
   assign out_data  = mem[rd_r[AW-1:0]];
   always @(posedge clk) begin
      if (in_valid && !full)
         mem[wr_r[AW-1:0]] <= in_data;
   end
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         wr_r <= {(AW+1){1'b0}};
         rd_r <= {(AW+1){1'b0}};
      end else begin
         if (in_valid && !full)
            wr_r <= wr_r + 1'b1;
         if (out_ready && !empty)
            rd_r <= rd_r + 1'b1;
      end
   end
endmodule

// >>> src/output_advance_and_ber_config.v
`timescale 1ns/10ps
`include "adv_ber_regs.vh"
// How it works
// - Thirty-two local advance registers from 0x83 hold a 2-bit code in bits 1-0.
// - Local code 0,1,2,3 advances that stream by 0,2,4,6 system clock cycles.
// - Code zero, the reset value, keeps the local stream on the frame pulse.
// - Thirty-two backplane advance registers from 0xA3; only sixteen used in 32 Mb/s mode.
// - In slow backplane modes codes 1,2,3 advance by 2,4,6 cycles.
// - In 32 Mb/s backplane mode codes 1,2,3 advance by 1,2,3 cycles.
// - Backplane code zero keeps the backplane stream on its frame pulse.
// - Send register bits 12-8 pick the local output stream carrying the test pattern.
// - Send register bits 7-0 give the first channel of the test pattern.
// - Each frame the pattern goes on the start channel plus the send length more channels.
// - Each frame the start channel plus the receive length more channels are checked.
// - Receive register bits 12-8 pick the local input stream that is checked.
// - Receive register bits 7-0 give the first channel compared.
// - A 16-bit read-only counter holds the number of detected errors.
module output_advance_and_ber_config #(
   parameter NSTREAM = 32,
   parameter FIFO_DEPTH = 8
) (
   input  wire          clk,
   input  wire          rst,
   input  wire [13:0]   addr,
   input  wire          wr_en,
   input  wire          rd_en,
   input  wire [15:0]   wr_data,
   output reg  [15:0]   rd_data,
   input  wire          back_32m_mode,
   output wire [63:0]   local_advance_code,
   output wire [63:0]   backplane_advance_code,
   output wire [95:0]   local_advance_cycles,
   output wire [95:0]   backplane_advance_cycles,
   input  wire          frame_start,
   input  wire          tx_slot,
   input  wire [4:0]    tx_stream,
   input  wire [7:0]    tx_channel,
   output reg           tx_insert,
   output reg  [7:0]    tx_byte,
   input  wire          rx_valid,
   output wire          rx_ready,
   input  wire [4:0]    rx_stream,
   input  wire [7:0]    rx_channel,
   input  wire [7:0]    rx_byte,
   output wire [4:0]    send_stream_select,
   output wire [4:0]    receive_stream_select,
   output wire [15:0]   local_test_error_count
);
   localparam FIFO_AW = $clog2(FIFO_DEPTH);

   reg  [1:0]  local_adv_r [0:NSTREAM-1];
   reg  [1:0]  back_adv_r  [0:NSTREAM-1];
   reg  [12:0] send_start_r;
   reg  [7:0]  send_len_r;
   reg  [7:0]  recv_len_r;
   reg  [12:0] recv_start_r;
   reg  [15:0] err_cnt_r;
   reg  [15:0] err_cnt_nxt;
   reg  [14:0] tx_prbs_r;
   reg  [14:0] rx_prbs_r;
   reg  [15:0] rd_nxt;
   wire        send_start_we;
   wire        send_len_we;
   wire        recv_len_we;
   wire        recv_start_we;
   wire [14:0] tx_base;
   wire        f_valid;
   wire        f_take;
   wire [7:0]  f_data;
   wire [7:0]  rx_expect;
   wire        in_win;
   wire        in_rx_win;
   wire [3:0]  ones;
   wire [16:0] err_sum;
   integer     k;

   // Top eight bits of the shift register, MSB first
   function [7:0] prbs_byte;
      input [14:0] s;
      prbs_byte = s[14:7];
   endfunction

   function [14:0] prbs_step;
      input [14:0] s;
      integer j;
      reg [14:0] t;
      begin
         t = s;
         for (j = 0; j < 8; j = j + 1)
            t = {t[13:0], t[14] ^ t[13]};
         prbs_step = t;
      end
   endfunction

   // Channel lies in start..start+len; sum kept 9 bits so wrap past 255 never matches
   function in_range;
      input [7:0] ch;
      input [7:0] start;
      input [7:0] len;
      reg [8:0] last;
      begin
         last = {1'b0, start} + {1'b0, len};
         in_range = ({1'b0, ch} >= {1'b0, start}) && ({1'b0, ch} <= last);
      end
   endfunction

   // Word match; index cut to the bus width on purpose
   function reg_hit;
      input [13:0] a;
      input [13:0] base;
      input integer idx;
      begin
         reg_hit = (a == base + idx[13:0]);
      end
   endfunction

   // The 32 Mb/s backplane steps by one cycle, all else by two
   function [2:0] adv_cycles;
      input [1:0] code;
      input       single_step;
      begin
         if (single_step) begin
            adv_cycles = {1'b0, code};
         end else begin
            adv_cycles = {code, 1'b0};
         end
      end
   endfunction

   function [3:0] bit_count;
      input [7:0] v;
      integer i;
      begin
         bit_count = 4'h0;
         for (i = 0; i < 8; i = i + 1) begin
            bit_count = bit_count + {3'h0, v[i]};
         end
      end
   endfunction

   genvar g;
   generate
      for (g = 0; g < NSTREAM; g = g + 1) begin : adv
         wire lhit;
         wire bhit;
         wire bopen;

         assign lhit  = wr_en && reg_hit(addr, `LOCAL_ADV_BASE, g);
         assign bhit  = wr_en && reg_hit(addr, `BACK_ADV_BASE, g);
         // Upper half of the backplane bank is unused at 32 Mb/s, so writes there are dropped
         assign bopen = !back_32m_mode || (g < `BACK32_STREAMS);
         always @(posedge clk or posedge rst) begin
            if (rst) begin
               local_adv_r[g] <= 2'h0;
               back_adv_r[g]  <= 2'h0;
            end else begin
               if (lhit) begin
                  local_adv_r[g] <= wr_data[`ADV_CODE_HI:0];
               end
               if (bhit && bopen) begin
                  back_adv_r[g] <= wr_data[`ADV_CODE_HI:0];
               end
            end
         end
         assign local_advance_code[2*g+1:2*g]       = local_adv_r[g];
         assign backplane_advance_code[2*g+1:2*g]   = back_adv_r[g];
         assign local_advance_cycles[3*g+2:3*g]     = adv_cycles(local_adv_r[g], 1'b0);
         assign backplane_advance_cycles[3*g+2:3*g] = adv_cycles(back_adv_r[g], back_32m_mode);
      end
   endgenerate

   assign send_start_we = wr_en && reg_hit(addr, `SEND_START_ADDR, 0);
   assign send_len_we   = wr_en && reg_hit(addr, `SEND_LEN_ADDR, 0);
   assign recv_len_we   = wr_en && reg_hit(addr, `RECV_LEN_ADDR, 0);
   assign recv_start_we = wr_en && reg_hit(addr, `RECV_START_ADDR, 0);

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         send_start_r <= 13'h0000;
         send_len_r   <= 8'h00;
         recv_len_r   <= 8'h00;
         recv_start_r <= 13'h0000;
      end else begin
         if (send_start_we) begin
            send_start_r <= wr_data[`STREAM_HI:0];
         end
         if (send_len_we) begin
            send_len_r <= wr_data[`CHAN_HI:0];
         end
         if (recv_len_we) begin
            recv_len_r <= wr_data[`CHAN_HI:0];
         end
         if (recv_start_we) begin
            recv_start_r <= wr_data[`STREAM_HI:0];
         end
      end
   end

   assign send_stream_select     = send_start_r[`STREAM_HI:`STREAM_LO];
   assign receive_stream_select  = recv_start_r[`STREAM_HI:`STREAM_LO];
   assign local_test_error_count = err_cnt_r;

   // Read mux; reserved bits and unmapped words give zero
   always @* begin
      rd_nxt = `REG_RESET;
      for (k = 0; k < NSTREAM; k = k + 1) begin
         if (reg_hit(addr, `LOCAL_ADV_BASE, k)) begin
            rd_nxt = {14'h0000, local_adv_r[k]};
         end
         if (reg_hit(addr, `BACK_ADV_BASE, k)) begin
            rd_nxt = {14'h0000, back_adv_r[k]};
         end
      end

      if (reg_hit(addr, `SEND_START_ADDR, 0)) begin
         rd_nxt = {3'h0, send_start_r};
      end
      if (reg_hit(addr, `SEND_LEN_ADDR, 0)) begin
         rd_nxt = {8'h00, send_len_r};
      end
      if (reg_hit(addr, `RECV_LEN_ADDR, 0)) begin
         rd_nxt = {8'h00, recv_len_r};
      end
      if (reg_hit(addr, `RECV_START_ADDR, 0)) begin
         rd_nxt = {3'h0, recv_start_r};
      end
      if (reg_hit(addr, `ERR_COUNT_ADDR, 0)) begin
         rd_nxt = err_cnt_r;
      end
   end

   // Error count has no write path, so software can only read it
   always @(posedge clk or posedge rst) begin
      if (rst)
         rd_data <= `REG_RESET;
      else if (rd_en)
         rd_data <= rd_nxt;
   end

   assign in_win = tx_slot && (tx_stream == send_stream_select) &&
                   in_range(tx_channel, send_start_r[`CHAN_HI:0], send_len_r);
   // A slot in the frame-start cycle already uses the fresh seed, so byte and insert agree
   assign tx_base = frame_start ? `PRBS_SEED : tx_prbs_r;

   // Pattern generator; sequence restarts on each frame so sender and checker agree
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         tx_prbs_r <= `PRBS_SEED;
         tx_insert <= 1'b0;
         tx_byte   <= 8'h00;
      end else begin
         tx_insert <= in_win;
         if (in_win) begin
            tx_byte   <= prbs_byte(tx_base);
            tx_prbs_r <= prbs_step(tx_base);
         end else if (frame_start) begin
            tx_prbs_r <= `PRBS_SEED;
         end
      end
   end

   // Received bytes queue here; a stalled checker back-pressures the receive side
   data_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) rx_fifo (
      .clk       (clk),
      .rst       (rst),
      .in_valid  (rx_valid && in_rx_win),
      .in_ready  (rx_ready),
      .in_data   (rx_byte),
      .out_valid (f_valid),
      .out_ready (f_take),
      .out_data  (f_data)
   );

   assign in_rx_win = (rx_stream == receive_stream_select) &&
                      in_range(rx_channel, recv_start_r[`CHAN_HI:0], recv_len_r);
   assign f_take    = !frame_start;
   assign rx_expect = prbs_byte(rx_prbs_r);
   assign ones      = bit_count(f_data ^ rx_expect);
   assign err_sum   = {1'b0, err_cnt_r} + {13'h0000, ones};

   // Saturates rather than wrapping so a bad link never reads as clean
   always @* begin
      if (err_sum > {1'b0, `ERR_COUNT_MAX}) begin
         err_cnt_nxt = `ERR_COUNT_MAX;
      end else begin
         err_cnt_nxt = err_sum[15:0];
      end
   end

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         rx_prbs_r <= `PRBS_SEED;
         err_cnt_r <= 16'h0000;
      end else if (frame_start) begin
         rx_prbs_r <= `PRBS_SEED;
      end else if (f_valid) begin
         rx_prbs_r <= prbs_step(rx_prbs_r);
         err_cnt_r <= err_cnt_nxt;
      end
   end
endmodule

// >>> dv/output_advance_and_ber_config_chk.sv
`timescale 1ns/10ps
module output_advance_and_ber_config_chk (
   input logic        clk,
   input logic        rst,
   input logic [13:0] addr,
   input logic        wr_en,
   input logic        rd_en,
   input logic [15:0] wr_data,
   input logic [15:0] rd_data,
   input logic        back_32m_mode,
   input logic [63:0] local_advance_code,
   input logic [63:0] backplane_advance_code,
   input logic [95:0] local_advance_cycles,
   input logic [95:0] backplane_advance_cycles,
   input logic        tx_slot,
   input logic [4:0]  tx_stream,
   input logic        tx_insert,
   input logic [4:0]  send_stream_select,
   input logic [15:0] local_test_error_count
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   rd_advance_a: assert property (rd_en && addr == 14'h0083 && !wr_en |=>
      rd_data == {14'h0000, local_advance_code[1:0]}) else $error("advance readback wrong");
   lcl_cycles_a: assert property (local_advance_cycles[5:3] == {local_advance_code[3:2], 1'b0})
      else $error("local advance cycles wrong");
   slow_cycles_a: assert property (!back_32m_mode |->
      backplane_advance_cycles[2:0] == {backplane_advance_code[1:0], 1'b0}) else $error("slow cycles wrong");
   fast_cycles_a: assert property (back_32m_mode |->
      backplane_advance_cycles[2:0] == {1'b0, backplane_advance_code[1:0]}) else $error("fast cycles wrong");
   send_stream_a: assert property (wr_en && addr == 14'h00c3 |=>
      send_stream_select == $past(wr_data[12:8])) else $error("send stream not updated");
   count_mono_a: assert property (local_test_error_count >= $past(local_test_error_count))
      else $error("error count went down");
   insert_slot_a: assert property (tx_insert |-> $past(tx_slot) && $past(tx_stream) == send_stream_select)
      else $error("insert without selected slot");
   b32_ignore_a: assert property (back_32m_mode && wr_en && addr == 14'h00b3 |=>
      $stable(backplane_advance_code[33:32])) else $error("upper backplane write taken");
endmodule
bind output_advance_and_ber_config output_advance_and_ber_config_chk chk (.clk, .rst, .addr, .wr_en, .rd_en,
   .wr_data, .rd_data, .back_32m_mode, .local_advance_code, .backplane_advance_code, .local_advance_cycles,
   .backplane_advance_cycles, .tx_slot, .tx_stream, .tx_insert, .send_stream_select, .local_test_error_count);

// >>> dv/stream_partner.sv
`timescale 1ns/10ps
module stream_partner (
   input  logic       clk,
   input  logic       tx_insert,
   input  logic [7:0] tx_byte,
   input  logic [7:0] tx_channel,
   input  logic [4:0] stream,
   input  logic [7:0] flip,
   input  logic       rx_ready,
   output logic       rx_valid = 0,
   output logic [4:0] rx_stream = 0,
   output logic [7:0] rx_channel = 0,
   output logic [7:0] rx_byte = 0
);
   logic [15:0] q[$];
   logic [7:0]  ch_d;
   // Loops sent bytes back, optionally corrupted
   always @(posedge clk) begin
      ch_d <= tx_channel;
      if (tx_insert)
         q.push_back({ch_d, tx_byte ^ flip});
      if (rx_valid && rx_ready)
         rx_valid <= 0;
      else if (!rx_valid && q.size() > 0) begin
         {rx_channel, rx_byte} <= q.pop_front();
         rx_stream <= stream;
         rx_valid <= 1;
      end else if (!rx_valid)
         rx_byte <= ~rx_byte;
   end
endmodule

// >>> dv/test_output_advance_and_ber_config.sv
`timescale 1ns/10ps
module test_output_advance_and_ber_config;
   logic        clk = 0, rst = 1, wr_en = 0, rd_en = 0, back_32m_mode = 0, frame_start = 0, tx_slot = 0;
   logic        rd_wait = 0, tx_insert, rx_valid, rx_ready;
   logic [4:0]  tx_stream = 0, stream = 5'h03, rx_stream, send_stream_select, receive_stream_select;
   logic [7:0]  tx_channel = 0, flip = 0, tx_byte, rx_channel, rx_byte;
   logic [13:0] addr = 0;
   logic [15:0] wr_data = 0, rd_data, local_test_error_count;
   logic [63:0] local_advance_code, backplane_advance_code;
   logic [95:0] local_advance_cycles, backplane_advance_cycles;
   logic [31:0] rs = 32'hd5e7;
   logic [15:0] eq[$];
   logic [1:0]  c[64];
   int          n_mismatch = 0, checks_done = 0, ins_n = 0, k;
   output_advance_and_ber_config dut (.*);
   stream_partner pm (.*);
   always #2 clk = ~clk;
   function automatic logic [31:0] xs(input logic [31:0] v);
      v ^= v << 13;
      v ^= v >> 17;
      v ^= v << 5;
      return v;
   endfunction
   task automatic cmp(input string n, input logic [15:0] e, input logic [15:0] g);
      checks_done++;
      if (g !== e) begin
         n_mismatch++;
         $display("[ERR] %s exp %h got %h", n, e, g);
      end
   endtask
   task wr(input logic [13:0] a, input logic [15:0] d);
      @(posedge clk) begin addr <= a; wr_data <= d; wr_en <= 1; end
      @(posedge clk) wr_en <= 0;
   endtask
   task rd(input logic [13:0] a, input logic [15:0] e);
      @(posedge clk) begin addr <= a; rd_en <= 1; eq.push_back(e); end
      @(posedge clk) rd_en <= 0;
   endtask
   always @(posedge clk) rd_wait <= rd_en;
   always @(negedge clk) if (rd_wait) cmp("rd_data", eq.pop_front(), rd_data);
   always @(negedge clk) if (tx_insert) ins_n++;
   task tally_and_finish;
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // One frame over streams 2 and 3, channels 0 to 20
   task frame(input logic [7:0] f, input logic [15:0] e);
      @(posedge clk) begin flip <= f; frame_start <= 1; end
      @(posedge clk) frame_start <= 0;
      ins_n = 0;
      for (int i = 0; i < 42; i++)
         @(posedge clk) begin tx_slot <= 1; tx_stream <= (i % 2) ? 5'h02 : 5'h03; tx_channel <= 8'(i / 2); end
      @(posedge clk) tx_slot <= 0;
      for (k = 0; k < 200 && local_test_error_count !== e; k++) @(posedge clk);
      if (k == 200) begin n_mismatch++; tally_and_finish(); end
      cmp("inserts", 16'h0004, 16'(ins_n));
      rd(14'h00c7, e);
   endtask
   initial begin
      repeat (6) @(posedge clk);
      rst <= 0;
      for (int i = 0; i < 70; i++) rd(14'(14'h0083 + i), 16'h0000);
      for (int i = 0; i < 64; i++) begin rs = xs(rs); wr(14'(14'h0083 + i), rs[15:0]); c[i] = rs[1:0]; end
      for (int i = 0; i < 64; i++) rd(14'(14'h0083 + i), {14'h0000, c[i]});
      @(negedge clk);
      for (int i = 0; i < 32; i++) begin
         cmp("local_cycles", {c[i], 1'b0}, 16'(local_advance_cycles[3*i+:3]));
         cmp("back_cycles", {c[32 + i], 1'b0}, 16'(backplane_advance_cycles[3*i+:3]));
      end
      @(posedge clk) back_32m_mode <= 1;
      for (int i = 0; i < 32; i++) begin rs = xs(rs); wr(14'(14'h00a3 + i), rs[15:0]); if (i < 16) c[32 + i] = rs[1:0]; end
      for (int i = 32; i < 64; i++) rd(14'(14'h0083 + i), {14'h0000, c[i]});
      @(negedge clk);
      for (int i = 0; i < 16; i++) cmp("fast_cycles", {1'b0, c[32 + i]}, 16'(backplane_advance_cycles[3*i+:3]));
      rs = xs(rs);
      for (int i = 0; i < 4; i++) wr(14'(14'h00c3 + i), rs[15:0]);
      wr(14'h00c7, 16'hffff);
      for (int i = 0; i < 4; i++) rd(14'(14'h00c3 + i), rs[15:0] & ((i % 3) ? 16'h00ff : 16'h1fff));
      rd(14'h00c7, 16'h0000);
      wr(14'h00c3, 16'h030a);
      wr(14'h00c4, 16'h0003);
      wr(14'h00c5, 16'h0003);
      wr(14'h00c6, 16'h030a);
      @(negedge clk);
      cmp("send_stream", 16'h0003, 16'(send_stream_select));
      cmp("recv_stream", 16'h0003, 16'(receive_stream_select));
      frame(8'h00, 16'h0000);
      frame(8'h81, 16'h0008);
      tally_and_finish();
   end
endmodule
